// file: rtl/fifap_pkg.sv
package fifap_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NSRC      = 32;
	localparam int STK_DEPTH = 8;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_SMR0    = 12'h000;
	localparam logic [11:0] OFS_SVR0    = 12'h080;
	localparam logic [11:0] OFS_IVR     = 12'h100;
	localparam logic [11:0] OFS_FVR     = 12'h104;
	localparam logic [11:0] OFS_ISR     = 12'h108;
	localparam logic [11:0] OFS_IPR     = 12'h10C;
	localparam logic [11:0] OFS_IMR     = 12'h110;
	localparam logic [11:0] OFS_CISR    = 12'h114;
	localparam logic [11:0] OFS_IECR    = 12'h120;
	localparam logic [11:0] OFS_IDCR    = 12'h124;
	localparam logic [11:0] OFS_ICCR    = 12'h128;
	localparam logic [11:0] OFS_ISCR    = 12'h12C;
	localparam logic [11:0] OFS_EOICR   = 12'h130;
	localparam logic [11:0] OFS_SPU     = 12'h134;
	localparam logic [11:0] OFS_DCR     = 12'h138;
	localparam logic [11:0] OFS_FFER    = 12'h140;
	localparam logic [11:0] OFS_FFDR    = 12'h144;
	localparam logic [11:0] OFS_FFSR    = 12'h148;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SMR_PRIO_LSB = 0;
	localparam int SMR_PRIO_MSB = 2;
	localparam int SMR_EDGE_BIT = 5;
	localparam int SMR_POL_BIT  = 6;
	localparam int DCR_PROTECT_ENABLE_BIT = 0;
	localparam int DCR_GLOBAL_REQUEST_MASK_BIT = 1;
	localparam int CISR_FIQ_BIT = 0;
	localparam int CISR_IRQ_BIT = 1;

	// ----------------------------------------
	// reset values and wiring
	// ----------------------------------------
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic [31:0] EXT_SRC_MASK = 32'h6000_0001;
	localparam logic [31:0] SMR_WR_MASK  = 32'h0000_0067;
	localparam logic [31:0] DCR_WR_MASK  = 32'h0000_0003;
	localparam logic [31:0] SRC0_MASK    = 32'h0000_0001;

endpackage

// file: rtl/fifap_top.sv
`timescale 1ns/1ns

// Operation
// - fast vector read clears source 0 only when it is edge-triggered.
// - forcing enable/disable writes set or clear bits of the forcing status.
// - forced source still detected but raises no normal request, skips priority.
// - forced level source asserts fast request while its active level is sampled.
// - forced edge source asserts fast request once its edge is detected.
// - forcing never alters the source 0 pending bit.
// - fast vector read always returns the source 0 vector.
// - fast vector read never clears a forced source; only clear command does.
// - normal vector read never clears a forced source.
// - source 0 keeps normal fast behaviour and joins the fast request.
// - writing 1 to the protect bit enables protect mode.
// - in protect mode context and current status update only on vector write.
// - protect-mode vector reads alone leave context and status unchanged.
// - normal-mode vector read computes, returns, records, pushes, acknowledges.
// - protect-mode read does first three steps; write pushes and acknowledges.
// - normal-mode vector write has no effect.
// - vector read with nothing pending returns the spurious vector.
// - global mask holds both request lines inactive.
// - global mask does not block the idle wake indication.
// - internal sources fixed high/rising; only external ones select low/falling.
// - with no pending source above the current level the vector read returns the spurious vector.
// - end of service pops the stack, restoring the previous level.
module fifap_top
	import fifap_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [NSRC-1:0]   src_in,
	output logic                   normal_request_n,
	output logic                   fast_request_n,
	output logic                   idle_wake
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [NSRC-1:0]                 s1;
		logic [NSRC-1:0]                 s2;
		logic [NSRC-1:0]                 s3;
		logic [NSRC-1:0]                 stab;
		logic [NSRC-1:0]                 act_q;
		logic [NSRC-1:0][6:0]            smr;
		logic [NSRC-1:0][31:0]           svr;
		logic [31:0]                     spurious_vector;
		logic [1:0]                      debug_control;
		logic [NSRC-1:0]                 imr;
		logic [NSRC-1:0]                 edge_pend;
		logic [NSRC-1:0]                 forcing_status;
		logic [STK_DEPTH-1:0][2:0]       stk_lvl;
		logic [STK_DEPTH-1:0][4:0]       stk_src;
		logic [3:0]                      depth;
		logic [4:0]                      held_src;
		logic                            held_v;
		logic                            pready;
		logic                            pslverr;
		logic [31:0]                     prdata;
		logic                            normal_request_n_n;
		logic                            fast_request_n_n;
		logic                            wake;
	} fifap_state_s;

	fifap_state_s r;
	fifap_state_s r_nxt;

	logic [NSRC-1:0] act;
	logic [NSRC-1:0] edg;
	logic [NSRC-1:0] pending_bits;

	// ----------------------------------------
	// per-source detection
	// ----------------------------------------
	genvar g;
	for (g = 0; g < NSRC; g++) begin : g_src
		assign act[g]          = r.stab[g] ^ (EXT_SRC_MASK[g] & ~r.smr[g][SMR_POL_BIT]);
		assign edg[g]          = r.smr[g][SMR_EDGE_BIT];
		assign pending_bits[g] = edg[g] ? r.edge_pend[g] : act[g];
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [NSRC-1:0] agree;
		logic [NSRC-1:0] cand;
		logic [NSRC-1:0] clr_m;
		logic [NSRC-1:0] set_m;
		logic [2:0]      best_p;
		logic [4:0]      best_s;
		logic            best_v;
		logic [2:0]      top_i;
		logic [2:0]      cur_lvl;
		logic            irq_want;
		logic            fiq_want;
		logic            access;
		logic            protect_enable;
		logic [4:0]      idx;
		logic [4:0]      push_src;
		logic            push;
		agree    = '0;
		cand     = '0;
		clr_m    = '0;
		set_m    = '0;
		best_p   = 3'h0;
		best_s   = 5'h00;
		best_v   = 1'b0;
		top_i    = 3'(r.depth - 4'h1);
		cur_lvl  = 3'h0;
		irq_want = 1'b0;
		fiq_want = 1'b0;
		access   = psel & penable & ~r.pready;
		protect_enable     = r.debug_control[DCR_PROTECT_ENABLE_BIT];
		idx      = paddr[6:2];
		push_src = 5'h00;
		push     = 1'b0;
		r_nxt    = r;

		// pins settle only when second and third stage agree
		r_nxt.s1    = src_in;
		r_nxt.s2    = r.s1;
		r_nxt.s3    = r.s2;
		agree       = ~(r.s2 ^ r.s3);
		r_nxt.stab  = (agree & r.s3) | (~agree & r.stab);
		r_nxt.act_q = act;

		cand = pending_bits & r.imr & ~r.forcing_status & ~SRC0_MASK;
		// ties go to the lowest source number
		for (int i = NSRC - 1; i > 0; i--) begin
			if (cand[i] && (!best_v || r.smr[i][SMR_PRIO_MSB:SMR_PRIO_LSB] >= best_p)) begin
				best_v = 1'b1;
				best_p = r.smr[i][SMR_PRIO_MSB:SMR_PRIO_LSB];
				best_s = 5'(i);
			end
		end
		if (r.depth != 4'h0) begin
			cur_lvl = r.stk_lvl[top_i];
		end
		irq_want = best_v && (r.depth == 4'h0 || best_p > cur_lvl);

		fiq_want = |(pending_bits & r.imr & (r.forcing_status | SRC0_MASK));

		// ----------------------------------------
		// register access
		// ----------------------------------------
		r_nxt.pready  = access;
		r_nxt.pslverr = 1'b0;
		r_nxt.prdata  = RST_WORD;
		if (access) begin
			if (paddr[1:0] != 2'b00) begin
				r_nxt.pslverr = 1'b1;
			end else if (paddr < OFS_SVR0) begin
				if (pwrite) begin
					r_nxt.smr[idx] = 7'(pwdata & SMR_WR_MASK);
				end else begin
					r_nxt.prdata = 32'(r.smr[idx]);
				end
			end else if (paddr < OFS_IVR) begin
				if (pwrite) begin
					r_nxt.svr[idx] = pwdata;
				end else begin
					r_nxt.prdata = r.svr[idx];
				end
			end else if (paddr == OFS_IVR) begin
				if (!pwrite) begin
					r_nxt.prdata = irq_want ? r.svr[best_s] : r.spurious_vector;
					if (protect_enable) begin
						r_nxt.held_src = best_s;
						r_nxt.held_v   = irq_want;
					end else if (irq_want) begin
						push     = 1'b1;
						push_src = best_s;
					end
				end else if (protect_enable && r.held_v) begin
					push         = 1'b1;
					push_src     = r.held_src;
					r_nxt.held_v = 1'b0;
				end
			end else if (paddr == OFS_FVR) begin
				if (!pwrite) begin
					r_nxt.prdata = r.svr[0];
					if (edg[0]) begin
						clr_m[0] = 1'b1;
					end
				end
			end else if (paddr == OFS_ISR) begin
				if (!pwrite && r.depth != 4'h0) begin
					r_nxt.prdata = 32'(r.stk_src[top_i]);
				end
			end else if (paddr == OFS_IPR) begin
				r_nxt.prdata = pwrite ? RST_WORD : pending_bits;
			end else if (paddr == OFS_IMR) begin
				r_nxt.prdata = pwrite ? RST_WORD : r.imr;
			end else if (paddr == OFS_CISR) begin
				if (!pwrite) begin
					r_nxt.prdata[CISR_FIQ_BIT] = ~r.fast_request_n_n;
					r_nxt.prdata[CISR_IRQ_BIT] = ~r.normal_request_n_n;
				end
			end else if (paddr == OFS_IECR) begin
				if (pwrite) begin
					r_nxt.imr = r.imr | pwdata;
				end
			end else if (paddr == OFS_IDCR) begin
				if (pwrite) begin
					r_nxt.imr = r.imr & ~pwdata;
				end
			end else if (paddr == OFS_ICCR) begin
				if (pwrite) begin
					clr_m = pwdata;
				end
			end else if (paddr == OFS_ISCR) begin
				if (pwrite) begin
					set_m = pwdata;
				end
			end else if (paddr == OFS_EOICR) begin
				if (pwrite && r.depth != 4'h0) begin
					r_nxt.depth = r.depth - 4'h1;
				end
			end else if (paddr == OFS_SPU) begin
				if (pwrite) begin
					r_nxt.spurious_vector = pwdata;
				end else begin
					r_nxt.prdata = r.spurious_vector;
				end
			end else if (paddr == OFS_DCR) begin
				if (pwrite) begin
					r_nxt.debug_control = 2'(pwdata & DCR_WR_MASK);
				end else begin
					r_nxt.prdata = 32'(r.debug_control);
				end
			end else if (paddr == OFS_FFER) begin
				if (pwrite) begin
					r_nxt.forcing_status = (r.forcing_status | pwdata) & ~SRC0_MASK;
				end
			end else if (paddr == OFS_FFDR) begin
				if (pwrite) begin
					r_nxt.forcing_status = r.forcing_status & ~pwdata;
				end
			end else if (paddr == OFS_FFSR) begin
				r_nxt.prdata = pwrite ? RST_WORD : r.forcing_status;
			end else begin
				r_nxt.pslverr = 1'b1;
			end
		end

		// ----------------------------------------
		// stacking and acknowledge
		// ----------------------------------------
		// a full stack drops the push rather than wrap over the oldest level
		if (push && r.depth != 4'(STK_DEPTH)) begin
			r_nxt.stk_lvl[r.depth[2:0]] = r.smr[push_src][SMR_PRIO_MSB:SMR_PRIO_LSB];
			r_nxt.stk_src[r.depth[2:0]] = push_src;
			r_nxt.depth                 = r.depth + 4'h1;
			if (edg[push_src] && !r.forcing_status[push_src]) begin
				clr_m[push_src] = 1'b1;
			end
		end

		// new edges win over a clear in the same cycle
		// detected edges latch only for edge-mode sources, so reset or a mode change leaves no stale edge
		r_nxt.edge_pend = (r.edge_pend & ~clr_m) | set_m | (act & ~r.act_q & edg);

		// ----------------------------------------
		// request lines
		// ----------------------------------------
		// global mask
		r_nxt.normal_request_n_n = ~(irq_want & ~r.debug_control[DCR_GLOBAL_REQUEST_MASK_BIT]);
		r_nxt.fast_request_n_n = ~(fiq_want & ~r.debug_control[DCR_GLOBAL_REQUEST_MASK_BIT]);
		r_nxt.wake   = irq_want | fiq_want;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r        <= '0;
			r.normal_request_n_n <= 1'b1;
			r.fast_request_n_n <= 1'b1;
		end else begin
			r <= r_nxt;
		end
	end

	assign prdata           = r.prdata;
	assign pready           = r.pready;
	assign pslverr          = r.pslverr;
	assign normal_request_n = r.normal_request_n_n;
	assign fast_request_n   = r.fast_request_n_n;
	assign idle_wake        = r.wake;

endmodule

// file: verif/fifap_checker.sv
`timescale 1ns/1ns
module fifap_checker
	import fifap_pkg::*;
(
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [11:0]     paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic [NSRC-1:0] src_in,
	input wire logic            normal_request_n,
	input wire logic            fast_request_n,
	input wire logic            idle_wake
);
	logic        global_request_mask_r;
	logic [31:0] svr0_r;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take;
		psel && penable && !pready;
	endsequence
	// ----------------------------------------
	// shadows of written mask bit and vector
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_request_mask_r <= 1'b0;
			svr0_r <= 32'h0000_0000;
		end else if (psel && penable && !pready && pwrite) begin
			if (paddr == OFS_DCR)
				global_request_mask_r <= pwdata[DCR_GLOBAL_REQUEST_MASK_BIT];
			if (paddr == OFS_SVR0)
				svr0_r <= pwdata;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_ready_wait: assert property (s_take |=> pready) else $error("no answer after access");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
	chk_err_pair: assert property (pslverr |-> pready) else $error("error without ready");
	chk_bad_align: assert property (s_take ##0 (paddr[1:0] != 2'b00) |=> pslverr) else $error("misaligned not refused");
	chk_fast_vector: assert property (s_take ##0 (!pwrite && paddr == OFS_FVR) |=> prdata == svr0_r)
		else $error("fast vector differs from source 0 vector");
	chk_mask_fast: assert property (global_request_mask_r && $past(global_request_mask_r) |-> fast_request_n)
		else $error("fast request under mask");
	chk_mask_normal: assert property (global_request_mask_r && $past(global_request_mask_r) |-> normal_request_n)
		else $error("normal request under mask");
	chk_mask_fall: assert property ($fell(fast_request_n) |-> !$past(global_request_mask_r))
		else $error("fast request fell while masked");
endmodule

bind fifap_top fifap_checker fifap_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.src_in(src_in), .normal_request_n(normal_request_n), .fast_request_n(fast_request_n), .idle_wake(idle_wake));

// file: verif/fifap_core_model.sv
`timescale 1ns/1ns
// core side: samples both request lines like a core input stage
module fifap_core_model
(
	input wire logic  pclk,
	input wire logic  presetn,
	input wire logic  normal_request_n,
	input wire logic  fast_request_n,
	output logic      irq_seen_r,
	output logic      fiq_seen_r
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_seen_r <= 1'b0;
			fiq_seen_r <= 1'b0;
		end else begin
			irq_seen_r <= irq_seen_r | !normal_request_n;
			fiq_seen_r <= fiq_seen_r | !fast_request_n;
		end
	end
endmodule

// file: verif/fast_irq_forcing_and_protect_tb.sv
`timescale 1ns/1ns
module fast_irq_forcing_and_protect_tb
	import fifap_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nrq_n, frq_n, wake, irq_s, fiq_s, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [NSRC-1:0] src;
	int err_count, checked, cyc;
	fifap_top fifap_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src),
		.normal_request_n(nrq_n), .fast_request_n(frq_n), .idle_wake(wake));
	fifap_core_model fifap_core_model_inst (.pclk(pclk), .presetn(presetn), .normal_request_n(nrq_n),
		.fast_request_n(frq_n), .irq_seen_r(irq_s), .fiq_seen_r(fiq_s));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			chk("pready", 32'h0000_0001, {31'h0, pready});
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	// waits a bounded time for a request line level
	task wq(input bit f, input logic v);
		for (int i = 0; i < 40; i++) begin
			@(posedge pclk);
			if ((f ? frq_n : nrq_n) === v)
				break;
		end
		chk(f ? "fast" : "normal", {31'h0, v}, {31'h0, f ? frq_n : nrq_n});
	endtask
	task settle();
		repeat (8) @(posedge pclk);
	endtask
	task complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_fast();
		apb(1'b1, OFS_SVR0, 32'h0000_1230);
		apb(1'b1, OFS_SPU, 32'h0000_5550);
		apb(1'b1, OFS_SMR0, 32'h0000_0060);
		apb(1'b1, OFS_IECR, 32'h0000_0001);
		src[0] <= 1'b1;
		wq(1'b1, 1'b0);
		rdc("fvr", OFS_FVR, 32'h0000_1230);
		settle();
		chk("fast edge clr", 32'h1, {31'h0, frq_n});
		src[0] <= 1'b0;
		apb(1'b1, OFS_SMR0, 32'h0000_0040);
		src[0] <= 1'b1;
		wq(1'b1, 1'b0);
		rdc("fvr", OFS_FVR, 32'h0000_1230);
		settle();
		chk("fast level", 32'h0, {31'h0, frq_n});
		src[0] <= 1'b0;
		wq(1'b1, 1'b1);
		$display("test fast done");
	endtask
	task t_force();
		apb(1'b1, OFS_FFER, 32'h0000_0020);
		rdc("ffsr", OFS_FFSR, 32'h0000_0020);
		apb(1'b1, 12'h014, 32'h0000_0020);
		apb(1'b1, OFS_IECR, 32'h0000_0020);
		src[5] <= 1'b1;
		wq(1'b1, 1'b0);
		chk("normal", 32'h1, {31'h0, nrq_n});
		rdc("ipr", OFS_IPR, 32'h0000_0020);
		rdc("fvr", OFS_FVR, 32'h0000_1230);
		settle();
		chk("fast kept", 32'h0, {31'h0, frq_n});
		rdc("ivr spur", OFS_IVR, 32'h0000_5550);
		// spurious handler ends with end of service
		apb(1'b1, OFS_EOICR, 32'h0000_0000);
		settle();
		chk("fast kept", 32'h0, {31'h0, frq_n});
		apb(1'b1, OFS_ICCR, 32'h0000_0020);
		wq(1'b1, 1'b1);
		apb(1'b1, OFS_FFDR, 32'h0000_0020);
		rdc("ffsr", OFS_FFSR, 32'h0000_0000);
		$display("test force done");
	endtask
	task t_protect_enable();
		apb(1'b1, 12'h098, 32'h0000_0660);
		apb(1'b1, 12'h018, 32'h0000_0024);
		apb(1'b1, OFS_IECR, 32'h0000_0040);
		apb(1'b1, OFS_DCR, 32'h0000_0001);
		src[6] <= 1'b1;
		wq(1'b0, 1'b0);
		for (int k = 0; k < 2; k++) begin
			rdc("ivr", OFS_IVR, 32'h0000_0660);
			rdc("isr", OFS_ISR, 32'h0000_0000);
		end
		apb(1'b1, OFS_IVR, 32'h0000_0000);
		rdc("isr", OFS_ISR, 32'h0000_0006);
		wq(1'b0, 1'b1);
		apb(1'b1, OFS_EOICR, 32'h0000_0000);
		rdc("isr", OFS_ISR, 32'h0000_0000);
		apb(1'b1, OFS_DCR, 32'h0000_0000);
		src[6] <= 1'b0;
		settle();
		src[6] <= 1'b1;
		wq(1'b0, 1'b0);
		apb(1'b1, OFS_IVR, 32'h0000_0000);
		settle();
		chk("normal", 32'h0, {31'h0, nrq_n});
		apb(1'b1, OFS_DCR, 32'h0000_0002);
		settle();
		chk("normal masked", 32'h1, {31'h0, nrq_n});
		chk("wake normal", 32'h1, {31'h0, wake});
		apb(1'b1, OFS_DCR, 32'h0000_0000);
		wq(1'b0, 1'b0);
		rdc("ivr", OFS_IVR, 32'h0000_0660);
		wq(1'b0, 1'b1);
		rdc("isr", OFS_ISR, 32'h0000_0006);
		apb(1'b1, OFS_EOICR, 32'h0000_0000);
		$display("test protect done");
	endtask
	task t_mask();
		src[0] <= 1'b1;
		wq(1'b1, 1'b0);
		apb(1'b1, OFS_DCR, 32'h0000_0002);
		settle();
		chk("fast masked", 32'h1, {31'h0, frq_n});
		chk("wake", 32'h1, {31'h0, wake});
		apb(1'b1, OFS_DCR, 32'h0000_0000);
		wq(1'b1, 1'b0);
		src[0] <= 1'b0;
		wq(1'b1, 1'b1);
		apb(1'b0, 12'h102, 32'h0000_0000);
		chk("misaligned", 32'h1, {31'h0, se});
		apb(1'b0, 12'h118, 32'h0000_0000);
		chk("unmapped", 32'h1, {31'h0, se});
		chk("core", 32'h3, {30'h0, irq_s, fiq_s});
		$display("test mask done");
	endtask
	// ----------------------------------------
	// clock, timeout, sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; src = 32'h6000_0000;
		err_count = 0; checked = 0; cyc = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_fast();
		t_force();
		t_protect_enable();
		t_mask();
		complete_run();
	end
endmodule
